// [src/smi_defs.vh]
// constants for the shift/move/indirect-load execution datapath
// assumes plain verilog-2005 includers; definitions only
`ifndef SMI_DEFS_VH
`define SMI_DEFS_VH
`define SMI_DW 8
`define SMI_AW 16
`define SMI_FW 7
`define SMI_OP_NONE 2'h0
`define SMI_OP_LSR 2'h1
`define SMI_OP_COPY 2'h2
`define SMI_OP_ILD 2'h3
`define SMI_PU_PREINC 2'h0
`define SMI_PU_PREDEC 2'h1
`define SMI_PU_POSTINC 2'h2
`define SMI_PU_POSTDEC 2'h3
`define SMI_ONE16 16'h0001
`define SMI_MSB 7
`define SMI_ZERO8 8'h00
`define SMI_ZERO16 16'h0000
// file addresses of the two indirect windows and pointer bytes
`define SMI_WIN0 7'h00
`define SMI_WIN1 7'h01
`define SMI_PTR0L 7'h04
`define SMI_PTR0H 7'h05
`define SMI_PTR1L 7'h06
`define SMI_PTR1H 7'h07
`define SMI_ST_IDLE 3'h1
`define SMI_ST_READ 3'h2
`define SMI_ST_DONE 3'h4
`endif

// [src/smi_ptr_file.v]
// the two 16-bit pointer registers, one write port each cycle
// assumes synchronous reset and a shared clock enable
`timescale 1ns/10ps
`include "smi_defs.vh"
module smi_ptr_file (
   input wire ref_clk,
   input wire rst,
   input wire clkEn,
   input wire wrEn,
   input wire wrSel,
   input wire [`SMI_AW-1:0] wrData,
   output wire [`SMI_AW-1:0] ptr0,
   output wire [`SMI_AW-1:0] ptr1
);
   reg [`SMI_AW-1:0] ptr_ff [0:1];
   genvar i;
   generate
      for (i = 0; i < 2; i = i + 1) begin : g_ptr
         always @(posedge ref_clk) begin
            if (rst) begin
               ptr_ff[i] <= `SMI_ZERO16;
            end else if (clkEn && wrEn && (wrSel == i)) begin
               ptr_ff[i] <= wrData;
            end
         end
      end
   endgenerate
   assign ptr0 = ptr_ff[0];
   assign ptr1 = ptr_ff[1];
endmodule // smi_ptr_file

// [src/smi_exec.v]
// execution datapath: right shift, register copy, indirect load
// assumes a data memory port with read data valid in the same cycle that memRd is high
`timescale 1ns/10ps
`include "smi_defs.vh"
module smi_exec (
   input wire ref_clk,
   input wire rst,
   input wire clkEn,
   input wire start,
   input wire [1:0] opSel,
   input wire [`SMI_FW-1:0] fileAddr,
   input wire destSel,
   input wire ptrIdx,
   input wire relMode,
   input wire [1:0] pointer_update_code,
   input wire [5:0] relOffset,
   input wire [`SMI_DW-1:0] memRdData,
   output wire busy,
   output reg done,
   output reg memRd,
   output reg memWr,
   output reg [`SMI_AW-1:0] memAddr,
   output reg [`SMI_DW-1:0] memWrData,
   output wire [`SMI_DW-1:0] accum,
   output wire carryFlag,
   output wire zeroFlag,
   output wire [`SMI_AW-1:0] pointer0,
   output wire [`SMI_AW-1:0] pointer1
);
   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg [`SMI_DW-1:0] acc_ff;
   reg [`SMI_DW-1:0] nxt_acc;
   reg carry_ff;
   reg nxt_carry;
   reg zero_ff;
   reg nxt_zero;
   reg [1:0] op_ff;
   reg dest_ff;
   reg [`SMI_AW-1:0] wbAddr_ff;
   reg nxt_done;
   reg nxt_memRd;
   reg nxt_memWr;
   reg [`SMI_AW-1:0] nxt_memAddr;
   reg [`SMI_DW-1:0] nxt_memWrData;
   reg [`SMI_AW-1:0] nxt_wbAddr;
   reg ptrWr;
   reg ptrWrSel;
   reg [`SMI_AW-1:0] ptrWrData;
   reg [`SMI_DW-1:0] result;
   reg [`SMI_AW-1:0] selPtr;
   reg [`SMI_AW-1:0] stepPtr;
   reg [`SMI_AW-1:0] offAddr;
   wire [`SMI_AW-1:0] ptr0;
   wire [`SMI_AW-1:0] ptr1;

   // operand address: a window name resolves to its pointer
   function [`SMI_AW-1:0] resolve;
      input [`SMI_FW-1:0] fa;
      input [`SMI_AW-1:0] p0;
      input [`SMI_AW-1:0] p1;
      begin
         if (fa == `SMI_WIN0) begin
            resolve = p0;
         end else if (fa == `SMI_WIN1) begin
            resolve = p1;
         end else begin
            resolve = {{(`SMI_AW-`SMI_FW){1'b0}}, fa};
         end
      end
   endfunction

   smi_ptr_file u_ptr (
      .ref_clk(ref_clk),
      .rst(rst),
      .clkEn(clkEn),
      .wrEn(ptrWr),
      .wrSel(ptrWrSel),
      .wrData(ptrWrData),
      .ptr0(ptr0),
      .ptr1(ptr1)
   );

   assign busy = !state_ff[0];
   assign accum = acc_ff;
   assign carryFlag = carry_ff;
   assign zeroFlag = zero_ff;
   assign pointer0 = ptr0;
   assign pointer1 = ptr1;

   always @* begin
      selPtr = ptrIdx ? ptr1 : ptr0;
      // 16-bit add drops the carry, so both ways wrap
      if (pointer_update_code[0]) begin
         stepPtr = selPtr - `SMI_ONE16;
      end else begin
         stepPtr = selPtr + `SMI_ONE16;
      end
      offAddr = selPtr + {{(`SMI_AW-6){relOffset[5]}}, relOffset};
      if (op_ff == `SMI_OP_LSR) begin
         result = {1'b0, memRdData[`SMI_MSB:1]};
      end else begin
         result = memRdData;
      end
   end

   always @* begin
      nxt_state = state_ff;
      nxt_acc = acc_ff;
      nxt_carry = carry_ff;
      nxt_zero = zero_ff;
      nxt_done = 1'b0;
      nxt_memRd = 1'b0;
      nxt_memWr = 1'b0;
      nxt_memAddr = memAddr;
      nxt_memWrData = memWrData;
      nxt_wbAddr = wbAddr_ff;
      ptrWr = 1'b0;
      ptrWrSel = ptrIdx;
      ptrWrData = stepPtr;
      case (state_ff)
         `SMI_ST_IDLE: begin
            if (start && opSel != `SMI_OP_NONE) begin
               nxt_memRd = 1'b1;
               nxt_state = `SMI_ST_READ;
               if (opSel == `SMI_OP_ILD) begin
                  if (relMode) begin
                     nxt_memAddr = offAddr;
                  end else if (!pointer_update_code[1]) begin
                     nxt_memAddr = stepPtr;
                  end else begin
                     nxt_memAddr = selPtr;
                  end
                  // the window itself never holds data
                  ptrWr = !relMode;
               end else begin
                  nxt_memAddr = resolve(fileAddr, ptr0, ptr1);
               end
               nxt_wbAddr = nxt_memAddr;
            end
         end
         `SMI_ST_READ: begin
            // read data arrive here; commit acc and flags this cycle, the memory write-back lands one cycle later
            nxt_state = `SMI_ST_DONE;
            nxt_done = 1'b1;
            nxt_zero = (result == `SMI_ZERO8);
            if (op_ff == `SMI_OP_LSR) begin
               nxt_carry = memRdData[0];
            end
            if (op_ff == `SMI_OP_ILD || !dest_ff) begin
               nxt_acc = result;
            end else begin
               nxt_memWr = 1'b1;
               nxt_memAddr = wbAddr_ff;
               nxt_memWrData = result;
            end
         end
         `SMI_ST_DONE: begin
            nxt_state = `SMI_ST_IDLE;
         end
         default: begin
            nxt_state = `SMI_ST_IDLE;
         end
      endcase
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         state_ff <= `SMI_ST_IDLE;
         acc_ff <= `SMI_ZERO8;
         carry_ff <= 1'b0;
         zero_ff <= 1'b0;
         op_ff <= `SMI_OP_NONE;
         dest_ff <= 1'b0;
         wbAddr_ff <= `SMI_ZERO16;
         done <= 1'b0;
         memRd <= 1'b0;
         memWr <= 1'b0;
         memAddr <= `SMI_ZERO16;
         memWrData <= `SMI_ZERO8;
      end else if (clkEn) begin
         state_ff <= nxt_state;
         acc_ff <= nxt_acc;
         carry_ff <= nxt_carry;
         zero_ff <= nxt_zero;
         if (state_ff == `SMI_ST_IDLE) begin
            op_ff <= opSel;
            dest_ff <= destSel;
         end
         wbAddr_ff <= nxt_wbAddr;
         done <= nxt_done;
         memRd <= nxt_memRd;
         memWr <= nxt_memWr;
         memAddr <= nxt_memAddr;
         memWrData <= nxt_memWrData;
      end
   end
endmodule // smi_exec

// [bench/smi_exec_monitor.sv]
// checker for the execution datapath timing and results
// assumes clkEn high whenever a request is in flight
`timescale 1ns/10ps
module smi_exec_chk (
   input logic ref_clk,
   input logic rst,
   input logic clkEn,
   input logic start,
   input logic busy,
   input logic [1:0] opSel,
   input logic destSel,
   input logic ptrIdx,
   input logic relMode,
   input logic [1:0] pointer_update_code,
   input logic [7:0] memRdData,
   input logic done,
   input logic memRd,
   input logic memWr,
   input logic [15:0] memAddr,
   input logic [7:0] memWrData,
   input logic [7:0] accum,
   input logic carryFlag,
   input logic zeroFlag,
   input logic [15:0] pointer0,
   input logic [15:0] pointer1
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire take = clkEn && start && !busy && opSel != 2'h0;
   read_issue_a: assert property (take |=> memRd && busy)
      else $error("no read after request");
   one_cycle_a: assert property (take ##1 clkEn |=> done)
      else $error("done late");
   shift_back_a: assert property (take && opSel == 2'h1 && destSel ##1 clkEn
      |=> memWr && !memWrData[7]) else $error("shift write-back wrong");
   shift_acc_a: assert property (take && opSel == 2'h1 && !destSel ##1 clkEn
      |=> !memWr && !accum[7]) else $error("shift to accumulator wrong");
   shift_flags_a: assert property (take && opSel == 2'h1 ##1 clkEn |=>
      carryFlag == $past(memRdData[0]) && zeroFlag == ($past(memRdData[7:1]) == 7'h00))
      else $error("shift flags wrong");
   copy_value_a: assert property (take && opSel == 2'h2 && !destSel ##1 clkEn |=>
      accum == $past(memRdData) && zeroFlag == (accum == 8'h00))
      else $error("copy result wrong");
   load_value_a: assert property (take && opSel == 2'h3 ##1 clkEn |=>
      accum == $past(memRdData) && !memWr) else $error("load result wrong");
   rel_keep_a: assert property (take && opSel == 2'h3 && relMode |=>
      $stable(pointer0) && $stable(pointer1)) else $error("offset moved pointer");
   post_inc_a: assert property (take && opSel == 2'h3 && !relMode && !ptrIdx
      && pointer_update_code == 2'h2 |=> memAddr == $past(pointer0)
      && pointer0 == $past(pointer0) + 16'h0001) else $error("postinc wrong");
   cover property (take && opSel == 2'h1);
   cover property (take && opSel == 2'h3 && relMode);
   cover property (done && memWr);
endmodule // smi_exec_chk
bind smi_exec smi_exec_chk chk (.*);

// [bench/smi_mem_model.sv]
// data memory behind the datapath, 64k bytes
// answers reads in the same cycle that memRd is high
`timescale 1ns/10ps
module smi_mem_model (
   input logic ref_clk,
   input logic memRd,
   input logic memWr,
   input logic [15:0] memAddr,
   input logic [7:0] memWrData,
   output logic [7:0] memRdData
);
   logic [7:0] mem [0:65535];
   initial begin
      for (int i = 0; i < 65536; i++) mem[i] = 8'(i);
   end
   // data stand while memRd is high, so the edge that ends it sees them
   // outside the read cycle show the inverse, never a usable value
   assign memRdData = memRd ? mem[memAddr] : ~mem[memAddr];
   always @(posedge ref_clk) begin
      if (memWr) mem[memAddr] <= memWrData;
   end
endmodule // smi_mem_model

// [bench/smi_exec_tb_top.sv]
// self-checking bench for smi_exec with a memory model
// assumes pointers reset to zero and window files 0/1
`timescale 1ns/10ps
module smi_exec_tb_top;
   logic ref_clk = 0, rst = 1, clkEn = 1, start = 0, destSel = 0;
   logic ptrIdx = 0, relMode = 0, busy, done, memRd, memWr;
   logic [1:0] opSel = 0, pointer_update_code = 0;
   logic [6:0] fileAddr = 0;
   logic [5:0] relOffset = 0;
   logic [7:0] memRdData, memWrData, accum, d, eAcc = 0;
   logic [15:0] memAddr, pointer0, pointer1, ea, p, eP [2] = '{0, 0};
   logic carryFlag, zeroFlag, eC = 0;
   int miscompares = 0, tests_run = 0, cyc = 0;
   smi_exec uut (.*);
   smi_mem_model uMem (.*);
   always #2 ref_clk = ~ref_clk;
   task tally_and_finish;
      $display("tests %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ceiling well above 208 ops of four cycles
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         miscompares++;
         tally_and_finish;
      end
   end
   task chk(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("Error %0t: got %h want %h", $time, g, e);
      end
   endtask
   task run(input logic [1:0] o, input logic [6:0] f, input logic ds,
      input logic ix, input logic rm, input logic [1:0] pc, input logic [5:0] ro);
      // let a pending write-back land before touching memory
      @(posedge ref_clk);
      #1;
      p = eP[ix];
      ea = (o != 2'h3 && f < 7'h2) ? eP[f[0]] : {9'h0, f};
      if (o == 2'h3) ea = rm ? p + {{10{ro[5]}}, ro} : pc[1] ? p : pc[0] ? p - 1 : p + 1;
      if (o == 2'h3 && !rm) eP[ix] = pc[0] ? p - 16'h1 : p + 16'h1;
      if (o != 2'h3) uMem.mem[ea] = $urandom_range(3) == 0 ? 8'h01 : 8'($urandom);
      d = uMem.mem[ea];
      if (o == 2'h1) eC = d[0];
      if (o == 2'h1) d = {1'b0, d[7:1]};
      if (o == 2'h3 || !ds) eAcc = d;
      @(posedge ref_clk);
      {start, opSel, fileAddr, destSel, ptrIdx, relMode, pointer_update_code,
         relOffset} <= {1'b1, o, f, ds, ix, rm, pc, ro};
      @(posedge ref_clk);
      start <= 0;
      for (int i = 0; i < 6 && done !== 1'b1; i++) begin
         @(posedge ref_clk);
         #1;
      end
      chk(done, 1);
      chk(memWr, o != 2'h3 && ds);
      if (o != 2'h3 && ds) chk(memWrData, d);
      chk(accum, eAcc);
      chk(zeroFlag, d == 8'h00);
      chk(carryFlag, eC);
      chk(pointer0, eP[0]);
      chk(pointer1, eP[1]);
      $display("op %0d addr %h checked", o, ea);
   endtask
   initial begin
      void'($urandom(32'h1b79));
      repeat (6) @(posedge ref_clk);
      rst <= 0;
      run(2'h3, 0, 0, 0, 0, 2'h1, 0);
      run(2'h3, 0, 0, 0, 0, 2'h0, 0);
      run(2'h3, 0, 0, 1, 0, 2'h3, 0);
      run(2'h3, 0, 0, 1, 0, 2'h2, 0);
      run(2'h3, 0, 0, 0, 1, 0, 6'h20);
      run(2'h3, 0, 0, 1, 1, 0, 6'h1f);
      run(2'h1, 7'h0, 1, 0, 0, 0, 0);
      run(2'h2, 7'h1, 0, 0, 0, 0, 0);
      repeat (200) run(2'($urandom_range(3, 1)), 7'($urandom_range(127, 8)),
         1'($urandom), 1'($urandom), 1'($urandom), 2'($urandom), 6'($urandom));
      tally_and_finish;
   end
endmodule // smi_exec_tb_top
